/* cbx_exec.sv */
/*
  Execution unit for flags-register transfers, flag logic, exception return,
  power-down, no-op and the counted byte block move.
  Assumes a word-wide memory port that holds each request until mem_ack, and
  a consumer of retired results behind a two-entry buffer.
*/
`timescale 1ns/10ps

module cbx_exec
  import cbx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cbx_pkg::cbx_op_e cmd_op,
  input wire logic [31:0] cmd_pc,
  input wire logic [7:0] cmd_imm8,
  input wire logic [23:0] cmd_disp,
  input wire logic [31:0] cmd_src_ext,
  input wire logic [31:0] cmd_dst_ext,
  input wire logic [31:0] cmd_sp,
  input wire logic [7:0] cmd_byte_count,
  input wire logic [15:0] cmd_word_count,
  input wire logic [15:0] cmd_src_ptr,
  input wire logic [15:0] cmd_dst_ptr,
  input wire logic cmd_onchip,
  input wire logic wake,
  output logic power_down,
  output logic [7:0] condition_code_reg,
  output logic mem_req,
  output logic mem_we,
  output logic mem_word,
  output logic [31:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic res_valid,
  input wire logic res_ready,
  output logic [7:0] res_flags,
  output logic [31:0] res_ext,
  output logic [31:0] res_pc,
  output logic [15:0] res_count,
  output logic [15:0] res_src_ptr,
  output logic [15:0] res_dst_ptr,
  output logic [7:0] res_byte,
  output logic [19:0] res_states,
  output logic res_states_ok
);

  typedef struct packed {
    logic [7:0] flags;
    logic [31:0] ext;
    logic [31:0] pc;
    logic [15:0] count;
    logic [15:0] sptr;
    logic [15:0] dptr;
    logic [7:0] byte_val;
    logic [19:0] states;
    logic states_ok;
  } cbx_res_s;

  typedef struct packed {
    cbx_fsm_e fsm;
    cbx_op_e op;
    cbx_res_s cur;
    logic pdown;
    logic cmd_rdy;
    logic req;
    logic we;
    logic word;
    logic [31:0] addr;
    logic [15:0] wdata;
    logic v0;
    logic v1;
    cbx_res_s b0;
    cbx_res_s b1;
  } cbx_st_s;

  cbx_st_s r;
  cbx_st_s next_r;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic pop;
    logic [31:0] ea;
    logic [15:0] mv_cnt;
    pop = 1'b0;
    ea = '0;
    mv_cnt = '0;
    next_r = r;
    pop = r.v0 & res_ready;
    if (pop) begin
      next_r.b0 = r.b1;
      next_r.v0 = r.v1;
      next_r.v1 = 1'b0;
    end
    unique case (r.fsm)
      CBX_IDLE: begin
        if (cmd_valid && r.cmd_rdy) begin
          next_r.op = cmd_op;
          next_r.cur.pc = cmd_pc + cbx_len(cmd_op);
          next_r.cur.ext = '0;
          next_r.cur.byte_val = '0;
          next_r.cur.states = '0;
          next_r.cur.states_ok = 1'b0;
          next_r.cur.count = '0;
          next_r.cur.sptr = cmd_src_ptr;
          next_r.cur.dptr = cmd_dst_ptr;
          next_r.fsm = CBX_RETIRE;
          next_r.we = 1'b0;
          next_r.word = 1'b1;
          unique case (cmd_op)
            CBX_LDC_IND, CBX_LDC_INC: ea = cmd_src_ext;
            CBX_LDC_D16: ea = cmd_src_ext + {{16{cmd_disp[15]}}, cmd_disp[15:0]};
            CBX_LDC_D24: ea = cmd_src_ext + {{8{cmd_disp[23]}}, cmd_disp};
            CBX_STC_IND: ea = cmd_dst_ext;
            CBX_STC_D16: ea = cmd_dst_ext + {{16{cmd_disp[15]}}, cmd_disp[15:0]};
            CBX_STC_D24: ea = cmd_dst_ext + {{8{cmd_disp[23]}}, cmd_disp};
            CBX_STC_DEC: ea = cmd_dst_ext - CBX_EXT_STEP;
            CBX_LDC_A16, CBX_STC_A16: ea = {16'h0000, cmd_disp[15:0]};
            CBX_LDC_A24, CBX_STC_A24: ea = {8'h00, cmd_disp};
            CBX_RTE: ea = cmd_sp;
            default: ea = '0;
          endcase
          unique case (cmd_op)
            CBX_SLEEP: next_r.pdown = 1'b1;
            CBX_LDC_IMM, CBX_LDC_REG: next_r.cur.flags = cmd_imm8;
            CBX_AND_FLAGS_INSTR: next_r.cur.flags = r.cur.flags & cmd_imm8;
            CBX_ORC: next_r.cur.flags = r.cur.flags | cmd_imm8;
            CBX_XOR_FLAGS_INSTR: next_r.cur.flags = r.cur.flags ^ cmd_imm8;
            CBX_STC_REG: next_r.cur.byte_val = r.cur.flags;
            CBX_RTE, CBX_LDC_IND, CBX_LDC_D16, CBX_LDC_D24, CBX_LDC_INC,
            CBX_LDC_A16, CBX_LDC_A24: begin
              next_r.cur.ext = (cmd_op == CBX_LDC_INC) ? cmd_src_ext : ea;
              next_r.req = 1'b1;
              next_r.addr = ea;
              next_r.fsm = CBX_RD;
            end
            CBX_STC_IND, CBX_STC_D16, CBX_STC_D24, CBX_STC_DEC,
            CBX_STC_A16, CBX_STC_A24: begin
              next_r.cur.ext = ea;
              next_r.req = 1'b1;
              next_r.we = 1'b1;
              next_r.addr = ea;
              next_r.wdata = {r.cur.flags, 8'h00};
              next_r.fsm = CBX_WR;
            end
            CBX_MOVE_B, CBX_MOVE_W: begin
              mv_cnt = (cmd_op == CBX_MOVE_B) ? {8'h00, cmd_byte_count} : cmd_word_count;
              next_r.cur.count = mv_cnt;
              next_r.cur.states = cbx_move_states(mv_cnt);
              next_r.cur.states_ok = cmd_onchip;
              if (mv_cnt != '0) begin
                next_r.req = 1'b1;
                next_r.word = 1'b0;
                next_r.addr = {16'h0000, cmd_src_ptr};
                next_r.fsm = CBX_MV_RD;
              end
            end
            default: next_r.fsm = CBX_RETIRE;
          endcase
        end
      end
      CBX_RD: begin
        if (mem_ack) begin
          next_r.cur.flags = mem_rdata[CBX_FLAGS_HI:CBX_FLAGS_LO];
          next_r.req = 1'b0;
          next_r.fsm = CBX_RETIRE;
          if (r.op == CBX_LDC_INC) begin
            next_r.cur.ext = r.cur.ext + CBX_EXT_STEP;
          end
          if (r.op == CBX_RTE) begin
            next_r.cur.ext = r.cur.ext + CBX_EXT_STEP;
            next_r.req = 1'b1;
            next_r.addr = r.cur.ext + CBX_EXT_STEP;
            next_r.fsm = CBX_RTE_PCH;
          end
        end
      end
      CBX_RTE_PCH: begin
        if (mem_ack) begin
          next_r.cur.pc[31:16] = mem_rdata;
          next_r.cur.ext = r.cur.ext + CBX_EXT_STEP;
          next_r.addr = r.cur.ext + CBX_EXT_STEP;
          next_r.fsm = CBX_RTE_PCL;
        end
      end
      CBX_RTE_PCL: begin
        if (mem_ack) begin
          next_r.cur.pc[15:0] = mem_rdata;
          next_r.cur.ext = r.cur.ext + CBX_EXT_STEP;
          next_r.req = 1'b0;
          next_r.fsm = CBX_RETIRE;
        end
      end
      CBX_WR: begin
        if (mem_ack) begin
          next_r.req = 1'b0;
          next_r.we = 1'b0;
          next_r.fsm = CBX_RETIRE;
        end
      end
      CBX_MV_RD: begin
        if (mem_ack) begin
          next_r.cur.byte_val = mem_rdata[CBX_BYTE_HI:0];
          next_r.we = 1'b1;
          next_r.addr = {16'h0000, r.cur.dptr};
          next_r.wdata = {8'h00, mem_rdata[CBX_BYTE_HI:0]};
          next_r.fsm = CBX_MV_WR;
        end
      end
      CBX_MV_WR: begin
        if (mem_ack) begin
          next_r.cur.sptr = r.cur.sptr + CBX_PTR_STEP;
          next_r.cur.dptr = r.cur.dptr + CBX_PTR_STEP;
          next_r.cur.count = r.cur.count - CBX_CNT_STEP;
          next_r.we = 1'b0;
          next_r.addr = {16'h0000, r.cur.sptr + CBX_PTR_STEP};
          next_r.fsm = CBX_MV_RD;
          if (r.cur.count == CBX_CNT_STEP) begin
            next_r.req = 1'b0;
            next_r.fsm = CBX_RETIRE;
          end
        end
      end
      CBX_RETIRE: begin
        if (!next_r.v1) begin
          if (!next_r.v0) begin
            next_r.b0 = r.cur;
            next_r.v0 = 1'b1;
          end else begin
            next_r.b1 = r.cur;
            next_r.v1 = 1'b1;
          end
          next_r.fsm = CBX_IDLE;
        end
      end
    endcase
    if (wake) begin
      next_r.pdown = 1'b0;
    end
    next_r.cmd_rdy = (next_r.fsm == CBX_IDLE) && !next_r.pdown;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.fsm <= CBX_IDLE;
      r.op <= CBX_NOP;
      r.cur.flags <= CBX_FLAGS_RESET;
      r.word <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign cmd_ready = r.cmd_rdy;
  assign power_down = r.pdown;
  assign condition_code_reg = r.cur.flags;
  assign mem_req = r.req;
  assign mem_we = r.we;
  assign mem_word = r.word;
  assign mem_addr = r.addr;
  assign mem_wdata = r.wdata;
  assign res_valid = r.v0;
  assign res_flags = r.b0.flags;
  assign res_ext = r.b0.ext;
  assign res_pc = r.b0.pc;
  assign res_count = r.b0.count;
  assign res_src_ptr = r.b0.sptr;
  assign res_dst_ptr = r.b0.dptr;
  assign res_byte = r.b0.byte_val;
  assign res_states = r.b0.states;
  assign res_states_ok = r.b0.states_ok;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic take;
  assign take = cmd_valid && cmd_ready;

  chk_disp16_load: assert property (
    (r.fsm == CBX_RD && mem_ack && r.op == CBX_LDC_D16)
      |=> (r.cur.flags == $past(mem_rdata[15:8]) && r.fsm == CBX_RETIRE))
    else $error("flags not loaded by displacement load");
  chk_disp24_addr: assert property (
    (take && cmd_op == CBX_LDC_D24) |=> (mem_addr == $past(cmd_src_ext)
      + {{8{$past(cmd_disp[23])}}, $past(cmd_disp)} && mem_req && !mem_we
      && r.cur.pc == $past(cmd_pc) + 32'h0000_000A))
    else $error("long displacement load address or length wrong");
  chk_postinc_step: assert property (
    (r.fsm == CBX_RD && mem_ack && r.op == CBX_LDC_INC)
      |=> r.cur.ext == $past(r.cur.ext) + 32'h0000_0002)
    else $error("post-increment did not add two");
  chk_predec_write: assert property (
    (take && cmd_op == CBX_STC_DEC) |=> (mem_we && mem_req
      && mem_addr == $past(cmd_dst_ext) - 32'h0000_0002 && mem_wdata[15:8] == r.cur.flags))
    else $error("pre-decrement store wrong");
  chk_store_flags: assert property (
    (r.fsm == CBX_WR) |=> $stable(r.cur.flags))
    else $error("store changed flags");
  chk_move_step: assert property (
    (r.fsm == CBX_MV_WR && mem_ack) |=> (r.cur.sptr == $past(r.cur.sptr) + 16'h0001
      && r.cur.dptr == $past(r.cur.dptr) + 16'h0001 && r.cur.count == $past(r.cur.count) - 16'h0001))
    else $error("move step wrong");
  chk_zero_skip: assert property (
    (take && cmd_op == CBX_MOVE_B && cmd_byte_count == 8'h00) |=> r.fsm == CBX_RETIRE ##1 !mem_req)
    else $error("zero-count byte move touched memory");
  chk_word_count: assert property (
    (take && cmd_op == CBX_MOVE_W) |=> r.cur.count == $past(cmd_word_count))
    else $error("word move count wrong");
  chk_move_states: assert property (
    (take && cmd_op == CBX_MOVE_B) |=> (r.cur.states == 20'h00008
      + {10'h000, $past(cmd_byte_count), 2'b00} && r.cur.states_ok == $past(cmd_onchip)))
    else $error("move state figure wrong");
  chk_rte_order: assert property (
    (r.fsm == CBX_RTE_PCH) |-> ($past(r.fsm) == CBX_RD || $past(r.fsm) == CBX_RTE_PCH))
    else $error("return popped counter before flags");
  chk_sleep_halt: assert property (
    (take && cmd_op == CBX_SLEEP) |=> (power_down && $stable(r.cur.flags)) ##1 (!cmd_ready || $past(wake)))
    else $error("power-down did not halt");

  cov_move_run: cover property (take && cmd_op == CBX_MOVE_W && cmd_word_count == 16'h0003);
  cov_rte_done: cover property (r.fsm == CBX_RTE_PCL && mem_ack);
  cov_buffer_full: cover property (r.v0 && r.v1 && !res_ready);
  cov_sleep_wake: cover property (power_down ##1 wake);

endmodule // cbx_exec

/* cbx_pkg.sv */
/*
  Shared constants and types for the flags-register and block-move execution unit.
  Assumes a core that hands over one decoded instruction at a time with its operands.
*/
package cbx_pkg;

  // ----------------------------------------------------------------
  // Decoded instruction forms
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CBX_NOP, CBX_SLEEP, CBX_RTE,
    CBX_LDC_IMM, CBX_LDC_REG, CBX_LDC_IND, CBX_LDC_D16, CBX_LDC_D24,
    CBX_LDC_INC, CBX_LDC_A16, CBX_LDC_A24,
    CBX_STC_REG, CBX_STC_IND, CBX_STC_D16, CBX_STC_D24,
    CBX_STC_DEC, CBX_STC_A16, CBX_STC_A24,
    CBX_AND_FLAGS_INSTR, CBX_ORC, CBX_XOR_FLAGS_INSTR,
    CBX_MOVE_B, CBX_MOVE_W
  } cbx_op_e;

  typedef enum logic [2:0] {
    CBX_IDLE, CBX_RD, CBX_RTE_PCH, CBX_RTE_PCL, CBX_WR, CBX_MV_RD, CBX_MV_WR, CBX_RETIRE
  } cbx_fsm_e;

  // ----------------------------------------------------------------
  // Encoding lengths in bytes
  // ----------------------------------------------------------------
  localparam logic [31:0] CBX_LEN_SHORT = 32'h0000_0002;
  localparam logic [31:0] CBX_LEN_IND = 32'h0000_0004;
  localparam logic [31:0] CBX_LEN_D16 = 32'h0000_0006;
  localparam logic [31:0] CBX_LEN_A24 = 32'h0000_0008;
  localparam logic [31:0] CBX_LEN_D24 = 32'h0000_000A;
  localparam logic [31:0] CBX_LEN_MOVE = 32'h0000_0004;

  // ----------------------------------------------------------------
  // Data layout, steps, reset values, timing
  // ----------------------------------------------------------------
  localparam int CBX_FLAGS_HI = 15;
  localparam int CBX_FLAGS_LO = 8;
  localparam int CBX_BYTE_HI = 7;
  localparam logic [7:0] CBX_FLAGS_RESET = 8'h80;
  localparam logic [31:0] CBX_EXT_STEP = 32'h0000_0002;
  localparam logic [15:0] CBX_PTR_STEP = 16'h0001;
  localparam logic [15:0] CBX_CNT_STEP = 16'h0001;
  localparam logic [19:0] CBX_MOVE_BASE = 20'h00008;
  localparam int CBX_MOVE_SHIFT = 2;

  function automatic logic [31:0] cbx_len(input cbx_op_e op);
    unique case (op)
      CBX_LDC_IND, CBX_LDC_INC, CBX_STC_IND, CBX_STC_DEC: cbx_len = CBX_LEN_IND;
      CBX_LDC_D16, CBX_LDC_A16, CBX_STC_D16, CBX_STC_A16: cbx_len = CBX_LEN_D16;
      CBX_LDC_D24, CBX_STC_D24: cbx_len = CBX_LEN_D24;
      CBX_LDC_A24, CBX_STC_A24: cbx_len = CBX_LEN_A24;
      CBX_MOVE_B, CBX_MOVE_W: cbx_len = CBX_LEN_MOVE;
      default: cbx_len = CBX_LEN_SHORT;
    endcase
  endfunction

  function automatic logic [19:0] cbx_move_states(input logic [15:0] n);
    cbx_move_states = CBX_MOVE_BASE + ({4'h0, n} << CBX_MOVE_SHIFT);
  endfunction

endpackage

/* cbx_mem_model.sv */
/*
  Memory partner for cbx_exec: 256 bytes, word reads big-endian.
  Assumes each request is held until mem_ack; lag sets the answer delay.
*/
`timescale 1ns/10ps
module cbx_mem_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] lag,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_word,
  input wire logic [31:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [7:0] mem [0:255];
  logic [3:0] wait_cnt;
  logic [7:0] a;
  logic in_range;
  assign a = mem_addr[7:0];
  assign in_range = (mem_addr[31:8] == 24'h000000);
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
      mem_rdata <= 16'h0000;
    end else begin
      mem_ack <= 1'b0;
      // Data lines toggle outside an answer, never hold stale values
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (wait_cnt == lag) begin
          wait_cnt <= 4'h0;
          mem_ack <= 1'b1;
          if (mem_we && in_range) begin
            mem[a] <= mem_word ? mem_wdata[15:8] : mem_wdata[7:0];
            if (mem_word) mem[a + 8'h01] <= mem_wdata[7:0];
          end else if (!mem_we) begin
            mem_rdata <= mem_word ? {mem[a], mem[a + 8'h01]} : {~mem[a], mem[a]};
            if (!in_range) mem_rdata <= 16'hDEAD;
          end
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule // cbx_mem_model

/* ccr_control_and_block_move_exec_test.sv */
/*
  Self-checking bench for cbx_exec with a memory partner.
  Assumes cbx_pkg and cbx_mem_model are compiled first.
*/
`timescale 1ns/10ps
module ccr_control_and_block_move_exec_test;
  import cbx_pkg::*;
  logic core_clk, rst_n, cmd_valid, cmd_ready, cmd_onchip, wake, power_down;
  cbx_op_e cmd_op;
  logic [31:0] cmd_pc, cmd_src_ext, cmd_dst_ext, cmd_sp, mem_addr, res_ext, res_pc;
  logic [7:0] cmd_imm8, cmd_byte_count, condition_code_reg, res_flags, res_byte;
  logic [23:0] cmd_disp;
  logic [15:0] cmd_word_count, cmd_src_ptr, cmd_dst_ptr, mem_wdata, mem_rdata;
  logic [15:0] res_count, res_src_ptr, res_dst_ptr;
  logic mem_req, mem_we, mem_word, mem_ack, res_valid, res_ready, res_states_ok;
  logic [19:0] res_states;
  logic [3:0] lag;
  logic [31:0] r_flags, r_ext, r_pc, r_count, r_src, r_dst, r_states, r_ok, r_byte;
  int fail_count, num_checks, cycles;

  cbx_exec dut (.core_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_pc, .cmd_imm8,
    .cmd_disp, .cmd_src_ext, .cmd_dst_ext, .cmd_sp, .cmd_byte_count, .cmd_word_count,
    .cmd_src_ptr, .cmd_dst_ptr, .cmd_onchip, .wake, .power_down, .condition_code_reg,
    .mem_req, .mem_we, .mem_word, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
    .res_valid, .res_ready, .res_flags, .res_ext, .res_pc, .res_count, .res_src_ptr,
    .res_dst_ptr, .res_byte, .res_states, .res_states_ok);
  cbx_mem_model mem_i (.core_clk, .rst_n, .lag, .mem_req, .mem_we, .mem_word,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

  always #4 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task send(input cbx_op_e op, input logic [31:0] pc);
    @(posedge core_clk);
    cmd_op <= op;
    cmd_pc <= pc;
    cmd_valid <= 1'b1;
    @(posedge core_clk);
    while (cmd_ready !== 1'b1) @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask

  task pop;
    @(posedge core_clk);
    res_ready <= 1'b1;
    @(posedge core_clk);
    while (res_valid !== 1'b1) @(posedge core_clk);
    r_flags = 32'(res_flags);
    r_ext = res_ext;
    r_pc = res_pc;
    r_count = 32'(res_count);
    r_src = 32'(res_src_ptr);
    r_dst = 32'(res_dst_ptr);
    r_states = 32'(res_states);
    r_ok = 32'(res_states_ok);
    r_byte = 32'(res_byte);
    res_ready <= 1'b0;
  endtask

  task run(input cbx_op_e op);
    send(op, 32'h0000_1000);
    pop();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_load;
    chk("flags reset", 32'h80, 32'(condition_code_reg));
    mem_i.mem[8'h40] = 8'h5A;
    mem_i.mem[8'h30] = 8'h3C;
    mem_i.mem[8'h60] = 8'hC3;
    @(posedge core_clk);
    cmd_src_ext <= 32'h0000_0050;
    cmd_disp <= 24'h00FFF0;
    lag <= 4'h2;
    run(CBX_LDC_D16);
    chk("flags d16", 32'h5A, r_flags);
    chk("pc d16", 32'h1006, r_pc);
    @(posedge core_clk);
    cmd_disp <= 24'hFFFFE0;
    run(CBX_LDC_D24);
    chk("flags d24", 32'h3C, r_flags);
    chk("pc d24", 32'h100A, r_pc);
    @(posedge core_clk);
    cmd_src_ext <= 32'h0000_0060;
    lag <= 4'h0;
    run(CBX_LDC_INC);
    chk("flags inc", 32'hC3, r_flags);
    chk("ext inc", 32'h62, r_ext);
    $display("test load done");
  endtask

  task t_store;
    mem_i.mem[8'h70] = 8'h00;
    mem_i.mem[8'h84] = 8'h00;
    mem_i.mem[8'h7C] = 8'h00;
    @(posedge core_clk);
    cmd_dst_ext <= 32'h0000_0072;
    run(CBX_STC_DEC);
    chk("mem dec", 32'hC3, 32'(mem_i.mem[8'h70]));
    chk("ext dec", 32'h70, r_ext);
    @(posedge core_clk);
    cmd_dst_ext <= 32'h0000_0080;
    cmd_disp <= 24'h000004;
    lag <= 4'h3;
    run(CBX_STC_D16);
    chk("mem d16", 32'hC3, 32'(mem_i.mem[8'h84]));
    chk("pc d16", 32'h1006, r_pc);
    chk("flags kept", 32'hC3, 32'(condition_code_reg));
    @(posedge core_clk);
    cmd_disp <= 24'hFFFFFC;
    run(CBX_STC_D24);
    chk("mem d24", 32'hC3, 32'(mem_i.mem[8'h7C]));
    chk("pc d24", 32'h100A, r_pc);
    $display("test store done");
  endtask

  task t_move;
    mem_i.mem[8'h10] = 8'h11;
    mem_i.mem[8'h11] = 8'h22;
    mem_i.mem[8'h12] = 8'h33;
    mem_i.mem[8'h23] = 8'h00;
    @(posedge core_clk);
    cmd_byte_count <= 8'h03;
    cmd_word_count <= 16'h0000;
    cmd_src_ptr <= 16'h0010;
    cmd_dst_ptr <= 16'h0020;
    cmd_onchip <= 1'b1;
    lag <= 4'h1;
    run(CBX_MOVE_B);
    chk("byte 0", 32'h11, 32'(mem_i.mem[8'h20]));
    chk("byte 2", 32'h33, 32'(mem_i.mem[8'h22]));
    chk("no extra", 32'h00, 32'(mem_i.mem[8'h23]));
    chk("count", 32'h0, r_count);
    chk("src", 32'h13, r_src);
    chk("dst", 32'h23, r_dst);
    chk("states b", 32'd20, r_states);
    chk("onchip", 32'h1, r_ok);
    chk("pc move", 32'h1004, r_pc);
    chk("last byte", 32'h33, r_byte);
    @(posedge core_clk);
    cmd_byte_count <= 8'h00;
    cmd_word_count <= 16'h0002;
    cmd_src_ptr <= 16'h0011;
    cmd_dst_ptr <= 16'h0030;
    cmd_onchip <= 1'b0;
    run(CBX_MOVE_W);
    chk("word 1", 32'h33, 32'(mem_i.mem[8'h31]));
    chk("dst w", 32'h32, r_dst);
    chk("states w", 32'd16, r_states);
    chk("offchip", 32'h0, r_ok);
    @(posedge core_clk);
    cmd_byte_count <= 8'h02;
    cmd_word_count <= 16'h0000;
    cmd_src_ptr <= 16'h0012;
    run(CBX_MOVE_W);
    chk("zero copy", 32'h22, 32'(mem_i.mem[8'h30]));
    chk("states 0", 32'd8, r_states);
    chk("pc zero", 32'h1004, r_pc);
    @(posedge core_clk);
    cmd_byte_count <= 8'h00;
    cmd_word_count <= 16'h0002;
    run(CBX_MOVE_B);
    chk("zero byte", 32'h22, 32'(mem_i.mem[8'h30]));
    chk("states 0b", 32'd8, r_states);
    $display("test move done");
  endtask

  task t_return_sleep;
    mem_i.mem[8'hA0] = 8'h1F;
    mem_i.mem[8'hA2] = 8'h12;
    mem_i.mem[8'hA3] = 8'h34;
    mem_i.mem[8'hA4] = 8'h56;
    mem_i.mem[8'hA5] = 8'h78;
    @(posedge core_clk);
    cmd_sp <= 32'h0000_00A0;
    run(CBX_RTE);
    chk("flags rte", 32'h1F, r_flags);
    chk("pc rte", 32'h1234_5678, r_pc);
    chk("sp rte", 32'hA6, r_ext);
    run(CBX_SLEEP);
    chk("flags sleep", 32'h1F, r_flags);
    repeat (4) @(posedge core_clk);
    chk("halted", 32'h1, 32'(power_down));
    chk("no take", 32'h0, 32'(cmd_ready));
    wake <= 1'b1;
    @(posedge core_clk);
    wake <= 1'b0;
    for (int i = 0; i < 8 && cmd_ready !== 1'b1; i++) @(posedge core_clk);
    chk("awake", 32'h0, 32'(power_down));
    $display("test return and sleep done");
  endtask

  task t_flags;
    @(posedge core_clk);
    cmd_imm8 <= 8'h0F;
    run(CBX_LDC_IMM);
    chk("flags imm", 32'h0F, r_flags);
    @(posedge core_clk);
    cmd_imm8 <= 8'h3C;
    run(CBX_AND_FLAGS_INSTR);
    chk("flags and", 32'h0C, r_flags);
    @(posedge core_clk);
    cmd_imm8 <= 8'h81;
    run(CBX_ORC);
    chk("flags or", 32'h8D, r_flags);
    @(posedge core_clk);
    cmd_imm8 <= 8'hFF;
    run(CBX_XOR_FLAGS_INSTR);
    chk("flags xor", 32'h72, r_flags);
    run(CBX_STC_REG);
    chk("flags to reg", 32'h72, r_byte);
    chk("pc short", 32'h1002, r_pc);
    @(posedge core_clk);
    cmd_imm8 <= 8'h55;
    cmd_src_ext <= 32'h0000_0040;
    cmd_dst_ext <= 32'h0000_0092;
    cmd_disp <= 24'h000090;
    run(CBX_LDC_REG);
    chk("flags reg", 32'h55, r_flags);
    run(CBX_STC_A24);
    chk("mem a24", 32'h55, 32'(mem_i.mem[8'h90]));
    chk("pc a24", 32'h1008, r_pc);
    run(CBX_STC_IND);
    chk("mem ind", 32'h55, 32'(mem_i.mem[8'h92]));
    chk("pc ind", 32'h1004, r_pc);
    run(CBX_LDC_IND);
    chk("flags ind", 32'h5A, r_flags);
    run(CBX_STC_A16);
    chk("mem a16", 32'h5A, 32'(mem_i.mem[8'h90]));
    chk("pc a16", 32'h1006, r_pc);
    @(posedge core_clk);
    cmd_disp <= 24'h000060;
    run(CBX_LDC_A24);
    chk("flags a24", 32'hC3, r_flags);
    $display("test flags done");
  endtask

  task t_buffer;
    // Receiver stalls: two results fill the buffer, third waits inside
    for (int i = 0; i < 3; i++) send(CBX_NOP, 32'h2000 + 32'(i) * 32'h10);
    repeat (6) @(posedge core_clk);
    chk("full stall", 32'h0, 32'(cmd_ready));
    for (int i = 0; i < 3; i++) begin
      pop();
      chk("order", 32'h2002 + 32'(i) * 32'h10, r_pc);
    end
    $display("test buffer done");
  endtask

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = CBX_NOP;
    cmd_pc = 32'h0000_1000;
    cmd_imm8 = 8'h00;
    cmd_disp = 24'h000000;
    cmd_src_ext = 32'h0;
    cmd_dst_ext = 32'h0;
    cmd_sp = 32'h0;
    cmd_byte_count = 8'h00;
    cmd_word_count = 16'h0000;
    cmd_src_ptr = 16'h0000;
    cmd_dst_ptr = 16'h0000;
    cmd_onchip = 1'b1;
    wake = 1'b0;
    res_ready = 1'b0;
    lag = 4'h0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_load();
    t_store();
    t_move();
    t_return_sleep();
    t_flags();
    t_buffer();
    results();
  end
endmodule // ccr_control_and_block_move_exec_test
